// File: common/oxp_pkg.sv
`default_nettype none
package oxp_pkg;
  localparam int SPEC_W = 16;
  localparam int BP_W = 42;
  localparam int FP_W = 46;
  localparam int NUM_OBJ = 4;
  localparam int NUM_BANDS = 11;
  localparam int NUM_SLOTS = 4;
  localparam int HIST_LEN = 10;
  localparam int FRAMES_PER_SEC = 50;
  localparam int FRAME_MS = 20;
  localparam logic [15:0] RATE_244 = 16'h00f4;
  localparam logic [15:0] RATE_320 = 16'h0140;
  localparam logic [1:0] FS_48K = 2'h0;
  localparam logic [1:0] FS_32K = 2'h1;
  localparam logic [1:0] FS_16K = 2'h2;
  localparam logic [7:0] BINS_48K = 8'hf0;
  localparam logic [7:0] BINS_32K = 8'ha0;
  localparam logic [7:0] BINS_16K = 8'h50;
  localparam logic [3:0] BANDS_WB = 4'hb;
  localparam logic [3:0] BANDS_NB = 4'h9;
  localparam logic [7:0] BORDER [0:10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h18, 8'h20,
                                           8'h2c, 8'h3c, 8'h54, 8'h7c};
  localparam logic [10:0] EQ_LO = 11'h3cf;
  localparam logic [10:0] EQ_MID = 11'h3e8;
  localparam logic [10:0] EQ_HI = 11'h401;
  localparam logic [9:0] HIST_RST = 10'h000;

  typedef enum logic [2:0] {
    ST_ACC = 3'b000,
    ST_BAND = 3'b001,
    ST_EQ = 3'b010,
    ST_NOISY = 3'b011,
    ST_DONE = 3'b100
  } oxp_state_e;

  typedef struct packed {
    logic frame_end;
    logic [1:0] obj;
    logic [7:0] bin;
    logic signed [SPEC_W-1:0] re;
    logic signed [SPEC_W-1:0] im;
  } oxp_tile_s;

  typedef struct packed {
    logic [3:0] band;
    logic [1:0] first;
    logic [1:0] second;
    logic [2:0] ratio;
  } oxp_band_s;

  function automatic logic [3:0] oxp_band_of(input logic [7:0] bin);
    logic [3:0] b;
    b = 4'h0;
    for (int l = 1; l <= 10; l++) begin
      if (bin >= BORDER[l]) begin
        b = 4'(l);
      end
    end
    return b;
  endfunction
endpackage
`default_nettype wire

// File: verification/oxp_extractor_tb.sv
`default_nettype none
module oxp_extractor_tb
  import oxp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Stimulus and monitors
  // ****
  localparam int az_exp [4] = '{127, 0, 95, 32};
  localparam int el_exp [4] = '{63, 0, 47, 16};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] rate = 16'h00f4;
  logic [2:0] nobj = 3'h4;
  logic [1:0] fs = 2'h0;
  logic [1:0] snr = 2'h3;
  logic [1:0] vad = 2'h0;
  logic slow = 1'b0;
  logic signed [8:0] azi [NUM_OBJ] = '{9'sd180, -9'sd180, 9'sd90, -9'sd90};
  logic signed [7:0] ele [NUM_OBJ] = '{8'sd90, -8'sd90, 8'sd45, -8'sd45};
  oxp_tile_s tile;
  oxp_band_s band;
  logic tvalid, tready, bvalid, mode, fvalid, eq, noisy;
  logic [6:0] azc [NUM_OBJ];
  logic [5:0] elc [NUM_OBJ];
  int bad_count = 0;
  int checks = 0;
  int fcount = 0;
  int cyc = 0;
  bit full_seen = 0;
  oxp_band_s bq[$];

  oxp_extractor #(.FIFO_DEPTH(8)) dut (
    .REF_CLK_I(clk), .SYS_RST_I(rst), .BITRATE_I(rate), .NUM_OBJ_I(nobj), .FS_SEL_I(fs),
    .TILE_I(tile), .TILE_VALID_I(tvalid), .TILE_READY_O(tready), .SNR_HINT_I(snr),
    .VAD_I(vad), .AZI_I(azi), .ELE_I(ele), .BAND_O(band), .BAND_VALID_O(bvalid),
    .MODE_O(mode), .FRAME_VALID_O(fvalid), .EQ_ENERGY_O(eq), .NOISY_O(noisy),
    .AZI_CODE_O(azc), .ELE_CODE_O(elc)
  );
  oxp_front_model front (
    .clk_i(clk), .rst_i(rst), .ready_i(tready), .slow_i(slow), .tile_o(tile), .valid_o(tvalid)
  );

  always #4 clk = ~clk;

  // Ceiling well above the few thousand cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (bvalid === 1'b1) bq.push_back(band);
    if (fvalid === 1'b1) fcount <= fcount + 1;
    if (tready === 1'b0 && !rst) full_seen <= 1'b1;
    if (cyc == 20000) begin
      bad_count++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input bit ok, input string msg);
    checks++;
    if (!ok) begin
      bad_count++;
      $display("Error %0t: %s", $time, msg);
    end
  endtask

  task automatic put(input int o, input int b, input int re, input int im, input bit f);
    front.q.push_back('{f, 2'(o), 8'(b), 16'(re), 16'(im)});
  endtask

  task automatic wait_frames(input int n);
    for (int i = 0; i < 3000 && fcount < n; i++) @(posedge clk);
    chk(fcount == n, "frame results missing");
  endtask

  function automatic int amp(input int o, input int b);
    int v;
    v = ((o + 1) * (b + 2)) % 5;
    // Band 1 carries a single object so the top ratio index is reached
    if (b == 1) v = (o == 2) ? 3 : 0;
    return (b == 0) ? 0 : (v > 3 ? 3 : v);
  endfunction

  // Two frames back to back, so with slow low the FIFO fills while the first is evaluated
  task automatic band_frame(input logic [1:0] fsel, input int nbins, input int nb);
    int p[4];
    int f, s, sum, n0, hi;
    oxp_band_s e;
    @(posedge clk);
    fs <= fsel;
    bq.delete();
    n0 = fcount;
    for (int r = 0; r < 2; r++) begin
      put(3, nbins, 500, 0, 1'b0);
      for (int b = 0; b < nb; b++) begin
        hi = (b == nb - 1) ? nbins : int'(BORDER[b + 1]);
        for (int o = 0; o < 4; o++) begin
          for (int k = 0; k < 4; k++) begin
            put(o, k[0] ? hi - 1 : int'(BORDER[b]), 9 * amp(o, b), -4 * amp(o, b),
                b == nb - 1 && o == 3 && k == 3);
          end
        end
      end
    end
    wait_frames(n0 + 2);
    chk(bq.size() == 2 * nb, "band count");
    for (int r = 0; r < 2; r++) begin
      for (int b = 0; b < nb; b++) begin
        for (int o = 0; o < 4; o++) p[o] = amp(o, b) ** 2;
        f = 0;
        for (int o = 1; o < 4; o++) if (p[o] > p[f]) f = o;
        s = (f == 0) ? 1 : 0;
        for (int o = 0; o < 4; o++) if (o != f && p[o] > p[s]) s = o;
        sum = p[f] + p[s];
        e = '{4'(b), 2'(f), 2'(s), 3'(sum == 0 ? 0 : (14 * (p[f] - p[s]) + sum) / (2 * sum))};
        chk(bq.size() > 0 && bq.pop_front() === e, "band result");
      end
    end
    for (int o = 0; o < 4; o++) begin
      chk(azc[o] === 7'(az_exp[o]) && elc[o] === 6'(el_exp[o]), "direction code");
    end
    chk(tready === 1'b1, "fifo not drained");
  endtask

  task automatic mode_table();
    logic [15:0] r[4] = '{16'h00f4, 16'h0140, 16'h00f3, 16'h0280};
    for (int i = 0; i < 4; i++) begin
      for (int n = 2; n <= 4; n++) begin
        @(posedge clk);
        rate <= r[i];
        nobj <= 3'(n);
        @(negedge clk);
        chk(mode === (i < 2 && n > 2), "mode select");
      end
    end
    @(posedge clk);
    rate <= 16'h0140;
    nobj <= 3'h4;
  endtask

  // Object 0 at 1024 against 1000 is inside the window; 1025 sits on its edge
  task automatic eq_frame(input int im0, input logic [1:0] sn, input logic [1:0] va);
    int n0;
    @(posedge clk);
    snr <= sn;
    vad <= va;
    n0 = fcount;
    for (int o = 0; o < 4; o++) put(o, 0, o ? 30 : 32, o ? 10 : im0, o == 3);
    wait_frames(n0 + 1);
  endtask

  task automatic noisy_run();
    logic [1:0] sn[4] = '{2'h1, 2'h2, 2'h3, 2'h3};
    logic [1:0] va[4] = '{2'h0, 2'h0, 2'h2, 2'h0};
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 10; i++) begin
        eq_frame(0, 2'h3, 2'h0);
        chk(eq === 1'b1, "equal energy");
        chk(noisy === (i == 9), "noisy history");
      end
      eq_frame(k == 3, sn[k], va[k]);
      chk(eq === (k != 3), "equal energy edge");
      chk(noisy === 1'b0, "noisy veto");
    end
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk(tready === 1'b1 && bvalid === 1'b0 && fvalid === 1'b0, "reset outputs");
    chk(noisy === 1'b0 && eq === 1'b0, "reset flags");
    mode_table();
    band_frame(FS_48K, 240, 11);
    chk(full_seen == 1'b1, "fifo never refused");
    slow <= 1'b1;
    band_frame(FS_32K, 160, 11);
    band_frame(FS_16K, 80, 9);
    slow <= 1'b0;
    noisy_run();
    wrap_up();
  end
endmodule
`default_nettype wire

// File: verification/oxp_front_model.sv
`default_nettype none
module oxp_front_model
  import oxp_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Tile stream
  input wire logic ready_i,
  input wire logic slow_i,
  output var oxp_tile_s tile_o,
  output var logic valid_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Spectral front end
  // ****
  oxp_tile_s q[$];
  logic tick_q = 1'b0;
  initial tile_o = '0;
  initial valid_o = 1'b0;
  // Offer held until taken; idle data scrambled so stale values never look valid
  always @(posedge clk_i) begin
    tick_q <= ~tick_q;
    if (rst_i) begin
      valid_o <= 1'b0;
    end else if (valid_o && !ready_i) begin
      valid_o <= 1'b1;
    end else if (q.size() > 0 && !(slow_i && tick_q)) begin
      tile_o <= q.pop_front();
      valid_o <= 1'b1;
    end else begin
      tile_o <= ~tile_o;
      valid_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: verilog/oxp_extractor.sv
`default_nettype none
module oxp_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [W-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_q, rd_q;
  logic [AW:0] cnt_q;
  logic push, pop;
  assign in_ready_o = (cnt_q != (AW+1)'(D));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem[rd_q];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_q] <= in_data_i;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= (wr_q == AW'(D-1)) ? '0 : wr_q + 1'b1;
      if (pop) rd_q <= (rd_q == AW'(D-1)) ? '0 : rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module oxp_extractor
  import oxp_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic REF_CLK_I,
  input wire logic SYS_RST_I,
  // Configuration
  input wire logic [15:0] BITRATE_I,
  input wire logic [2:0] NUM_OBJ_I,
  input wire logic [1:0] FS_SEL_I,
  // Spectral tile stream
  input wire oxp_tile_s TILE_I,
  input wire logic TILE_VALID_I,
  output logic TILE_READY_O,
  // Core coder hints and directions
  input wire logic [1:0] SNR_HINT_I,
  input wire logic [1:0] VAD_I,
  input wire logic signed [8:0] AZI_I [NUM_OBJ],
  input wire logic signed [7:0] ELE_I [NUM_OBJ],
  // Band parameters
  output oxp_band_s BAND_O,
  output logic BAND_VALID_O,
  // Frame parameters
  output logic MODE_O,
  output logic FRAME_VALID_O,
  output logic EQ_ENERGY_O,
  output logic NOISY_O,
  output logic [6:0] AZI_CODE_O [NUM_OBJ],
  output logic [5:0] ELE_CODE_O [NUM_OBJ]
);
  // ****************************************
  // Input buffering
  // ****************************************
  oxp_tile_s tile;
  logic tile_valid, tile_ready, take;
  oxp_state_e st_q;
  oxp_fifo #(.W($bits(oxp_tile_s)), .D(FIFO_DEPTH)) u_fifo (
    .clk_i(REF_CLK_I),
    .rst_i(SYS_RST_I),
    .in_data_i(TILE_I),
    .in_valid_i(TILE_VALID_I),
    .in_ready_o(TILE_READY_O),
    .out_data_o(tile),
    .out_valid_o(tile_valid),
    .out_ready_i(tile_ready)
  );
  // Stall the drain while a finished frame is evaluated; the FIFO takes up to FIFO_DEPTH tiles of the gap
  assign tile_ready = (st_q == ST_ACC);
  assign take = tile_valid & tile_ready;

  // ****************************************
  // Mode and geometry
  // ****************************************
  logic mode;
  logic [7:0] nbins;
  logic [3:0] nbands;
  assign mode = ((BITRATE_I == RATE_244) || (BITRATE_I == RATE_320))
                && ((NUM_OBJ_I == 3'h3) || (NUM_OBJ_I == 3'h4));
  assign MODE_O = mode;
  assign nbins = (FS_SEL_I == FS_16K) ? BINS_16K :
                 (FS_SEL_I == FS_32K) ? BINS_32K : BINS_48K;
  assign nbands = (FS_SEL_I == FS_16K) ? BANDS_NB : BANDS_WB;

  // ****************************************
  // Band power accumulation
  // ****************************************
  logic [BP_W-1:0] bp_q [NUM_OBJ][NUM_BANDS];
  logic [FP_W-1:0] fp_q [NUM_OBJ];
  logic [2*SPEC_W-1:0] tpow;
  logic [3:0] band_q;
  logic signed [2*SPEC_W-1:0] sq_re, sq_im;
  // Full-width signed squares; their sum always fits the unsigned word
  assign sq_re = $signed(tile.re) * $signed(tile.re);
  assign sq_im = $signed(tile.im) * $signed(tile.im);
  assign tpow = sq_re + sq_im;
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I || st_q == ST_DONE) begin
      for (int i = 0; i < NUM_OBJ; i++) begin
        for (int l = 0; l < NUM_BANDS; l++) bp_q[i][l] <= '0;
      end
    end else if (take && mode && tile.bin < nbins && 3'(tile.obj) < NUM_OBJ_I) begin
      // All slots of the frame land in the same band cell; upper border is exclusive
      bp_q[tile.obj][oxp_band_of(tile.bin)] <=
        bp_q[tile.obj][oxp_band_of(tile.bin)] + BP_W'(tpow);
    end
  end

  // ****************************************
  // Band selection and ratio
  // ****************************************
  logic [1:0] i1, i2;
  logic [BP_W-1:0] p1, p2;
  always_comb begin
    i1 = 2'h0;
    i2 = 2'h1;
    p1 = '0;
    p2 = '0;
    for (int i = 0; i < NUM_OBJ; i++) begin
      if (3'(i) < NUM_OBJ_I) begin
        // Strict compare keeps the lower index ahead on equal power
        if (i == 0 || bp_q[i][band_q] > p1) begin
          if (i != 0) begin
            i2 = i1;
            p2 = p1;
          end
          i1 = 2'(i);
          p1 = bp_q[i][band_q];
        end else if (i == 1 || bp_q[i][band_q] > p2) begin
          i2 = 2'(i);
          p2 = bp_q[i][band_q];
        end
      end
    end
  end

  function automatic logic [2:0] ratio_idx(input logic [BP_W-1:0] a, input logic [BP_W-1:0] b);
    logic [BP_W+4:0] s, d;
    logic [2:0] n;
    s = (BP_W+5)'(a) + (BP_W+5)'(b);
    d = (BP_W+5)'(a - b) * (BP_W+5)'(14);
    n = 3'h0;
    if (s != '0) begin
      for (int k = 1; k < 8; k++) begin
        if (d >= s * (BP_W+5)'(2*k-1)) n = n + 3'h1;
      end
    end
    return n;
  endfunction

  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      BAND_O <= '0;
      BAND_VALID_O <= 1'b0;
    end else begin
      BAND_VALID_O <= (st_q == ST_BAND);
      if (st_q == ST_BAND) begin
        BAND_O <= '{band: band_q, first: i1, second: i2, ratio: ratio_idx(p1, p2)};
      end
    end
  end

  // ****************************************
  // Frame sequencing
  // ****************************************
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      st_q <= ST_ACC;
      band_q <= 4'h0;
    end else begin
      case (st_q)
        ST_ACC: begin
          band_q <= 4'h0;
          if (take && tile.frame_end && mode) st_q <= ST_BAND;
        end
        ST_BAND: begin
          band_q <= band_q + 4'h1;
          if (band_q == nbands - 4'h1) st_q <= ST_EQ;
        end
        ST_EQ: st_q <= ST_NOISY;
        ST_NOISY: st_q <= ST_DONE;
        ST_DONE: st_q <= ST_ACC;
        default: st_q <= ST_ACC;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I || st_q == ST_DONE) begin
      for (int i = 0; i < NUM_OBJ; i++) fp_q[i] <= '0;
    end else if (st_q == ST_BAND) begin
      for (int i = 0; i < NUM_OBJ; i++) fp_q[i] <= fp_q[i] + FP_W'(bp_q[i][band_q]);
    end
  end

  // ****************************************
  // Equal energy, noisy speech, directions
  // ****************************************
  logic eq;
  logic cand;
  logic [HIST_LEN-1:0] hist_q;
  always_comb begin
    eq = 1'b1;
    for (int i = 1; i < NUM_OBJ; i++) begin
      if (3'(i) < NUM_OBJ_I) begin
        if (!((FP_W+11)'(fp_q[i]) * (FP_W+11)'(EQ_LO) < (FP_W+11)'(fp_q[0]) * (FP_W+11)'(EQ_MID)
            && (FP_W+11)'(fp_q[0]) * (FP_W+11)'(EQ_MID) < (FP_W+11)'(fp_q[i]) * (FP_W+11)'(EQ_HI)))
          eq = 1'b0;
      end
    end
  end
  assign cand = EQ_ENERGY_O & (&SNR_HINT_I) & ~(|VAD_I);

  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      EQ_ENERGY_O <= 1'b0;
      NOISY_O <= 1'b0;
      hist_q <= HIST_RST;
      FRAME_VALID_O <= 1'b0;
      for (int i = 0; i < NUM_OBJ; i++) begin
        AZI_CODE_O[i] <= '0;
        ELE_CODE_O[i] <= '0;
      end
    end else begin
      FRAME_VALID_O <= (st_q == ST_NOISY);
      if (st_q == ST_EQ) begin
        EQ_ENERGY_O <= eq;
        for (int i = 0; i < NUM_OBJ; i++) begin
          // Uniform grid; finer direction tables live with the metadata coder
          AZI_CODE_O[i] <= 7'((16'(AZI_I[i] + 9'sd180) * 16'd127 + 16'd180) / 16'd360);
          ELE_CODE_O[i] <= 6'((16'(ELE_I[i] + 8'sd90) * 16'd63 + 16'd90) / 16'd180);
        end
      end
      if (st_q == ST_NOISY) begin
        hist_q <= {hist_q[HIST_LEN-2:0], cand};
        // Held for the packer and for the SID payload until the next frame
        NOISY_O <= cand & (&hist_q[HIST_LEN-2:0]);
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  chk_frame_mode: assert property (st_q == ST_BAND |-> MODE_O)
    else $error("band evaluation outside object mode");
  chk_band_pair: assert property (BAND_VALID_O |-> BAND_O.first != BAND_O.second)
    else $error("same object picked twice");
  chk_zero_ratio: assert property (st_q == ST_BAND && p1 == '0 |=> BAND_O.ratio == 3'h0)
    else $error("zero powers did not give half ratio");
  chk_ratio_top: assert property (st_q == ST_BAND && p1 != '0 && p2 == '0
                                  |=> BAND_O.ratio == 3'h7)
    else $error("lone power not clamped to top index");
  chk_tie_order: assert property (st_q == ST_BAND && p1 == p2 |=> BAND_O.first < BAND_O.second)
    else $error("tie not ranked by lower index");
  chk_noisy_zero: assert property (FRAME_VALID_O && !EQ_ENERGY_O |-> !NOISY_O)
    else $error("noisy set without equal energy");
  chk_noisy_hist: assert property (FRAME_VALID_O && NOISY_O |-> &hist_q)
    else $error("noisy set with zero in history");
  chk_frame_seq: assert property (st_q == ST_BAND && band_q == nbands - 4'h1
                                  |=> st_q == ST_EQ ##2 FRAME_VALID_O)
    else $error("frame result not on time");
  chk_hist_push: assert property (FRAME_VALID_O |-> hist_q[0] == $past(cand))
    else $error("history did not take the new candidate");
  chk_band_range: assert property (BAND_VALID_O |-> BAND_O.band < nbands)
    else $error("band index beyond band count");

  // Covers mark the scenarios the bench is expected to reach
  cov_noisy: cover property (FRAME_VALID_O && NOISY_O);
  cov_equal: cover property (FRAME_VALID_O && EQ_ENERGY_O);
  cov_stall: cover property (TILE_VALID_I && !TILE_READY_O);
  cov_top_ratio: cover property (BAND_VALID_O && BAND_O.ratio == 3'h7);
  cov_veto: cover property (FRAME_VALID_O && EQ_ENERGY_O && !NOISY_O);
endmodule
`default_nettype wire
